// ### rtl/lcp_pkg.sv
// Package of constants and types for the LCD driver serial command port.
package lcp_pkg;

  localparam logic [5:0] LCP_ADDR_HIGH = 6'h1c;
  localparam logic [3:0] LCP_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LCP_ACK_SLOT = 4'h9;

  localparam logic [3:0] LCP_OP_MODE_SET = 4'hc;
  localparam logic [4:0] LCP_OP_DEV_SEL = 5'h1c;
  localparam logic [5:0] LCP_OP_BANK_SEL = 6'h3e;
  localparam logic [4:0] LCP_OP_BLINK_SEL = 5'h1e;

  localparam int LCP_CTRL_MORE_BIT = 7;
  localparam int LCP_CTRL_ROUTE_BIT = 6;
  localparam int LCP_MODE_ENABLE_BIT = 3;
  localparam int LCP_MODE_BIAS_BIT = 2;
  localparam int LCP_BANK_IN_BIT = 1;
  localparam int LCP_BANK_OUT_BIT = 0;
  localparam int LCP_BLINK_ALT_BIT = 2;

  localparam logic [1:0] LCP_DRIVE_STATIC = 2'h1;
  localparam logic [1:0] LCP_DRIVE_MUX2 = 2'h2;
  localparam logic [1:0] LCP_DRIVE_MUX3 = 2'h3;
  localparam logic [1:0] LCP_DRIVE_MUX4 = 2'h0;

  localparam logic LCP_RST_ENABLE = 1'b0;
  localparam logic LCP_RST_BIAS_HALF = 1'b0;
  localparam logic [1:0] LCP_RST_DRIVE = 2'h1;
  localparam logic [1:0] LCP_RST_FLASH = 2'h0;

  typedef enum logic [4:0] {
    LCP_LK_IDLE = 5'b00001,
    LCP_LK_ADDR = 5'b00010,
    LCP_LK_CTRL = 5'b00100,
    LCP_LK_BYTE = 5'b01000,
    LCP_LK_SKIP = 5'b10000
  } lcp_link_st_t;

  typedef struct packed {
    logic display_enable;
    logic bias_half;
    logic [1:0] drive_mode;
    logic input_bank;
    logic output_bank;
    logic bank_toggle_blink;
    logic [1:0] flash_rate;
  } lcp_mode_t;

  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } lcp_xfer_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic sa_s1;
    logic sa_s2;
    logic match_s1;
    logic match_s2;
    lcp_link_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ack_want;
    logic ack_drive;
    logic more_follows_flag;
    logic byte_route_select;
    logic xfer_tgl;
    lcp_xfer_t xfer;
  } lcp_link_t;

  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_d;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic match;
    logic ptr_load;
    logic [6:0] ptr_value;
    logic sub_load;
    logic [2:0] sub_value;
    logic write_strobe;
    logic [7:0] write_data;
    lcp_mode_t mode;
  } lcp_sys_t;

endpackage

// ### rtl/lcp_command_port.sv
// Serial slave receiver and command decoder of the LCD driver.
`timescale 1ns/1ps
module lcp_command_port
  import lcp_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic SCL,
  input wire logic SDA,
  input wire logic ADDR_LSB_STRAP,
  input wire logic STRAP_BIT_0,
  input wire logic STRAP_BIT_1,
  input wire logic STRAP_BIT_2,
  input wire logic [2:0] SUBADDR_COUNT,
  output logic ACK_OUT_PIN,
  output logic ACK_OUT_PIN_OE,
  output logic PTR_LOAD,
  output logic [6:0] PTR_VALUE,
  output logic SUBADDR_LOAD,
  output logic [2:0] SUBADDR_VALUE,
  output logic WRITE_STROBE,
  output logic [7:0] WRITE_DATA,
  output lcp_mode_t MODE_STATE
);

  lcp_link_t lk;
  lcp_link_t next_lk;
  lcp_sys_t sy;
  lcp_sys_t next_sy;

  // Link side: oversamples the bus lines on the link clock.
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rx;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    rx = 8'h00;
    next_lk = lk;
    next_lk.scl_s1 = SCL;
    next_lk.scl_s2 = lk.scl_s1;
    next_lk.scl_d = lk.scl_s2;
    next_lk.sda_s1 = SDA;
    next_lk.sda_s2 = lk.sda_s1;
    next_lk.sda_d = lk.sda_s2;
    next_lk.sa_s1 = ADDR_LSB_STRAP;
    next_lk.sa_s2 = lk.sa_s1;
    next_lk.match_s1 = sy.match;
    next_lk.match_s2 = lk.match_s1;
    scl_rise = lk.scl_s2 & ~lk.scl_d;
    scl_fall = ~lk.scl_s2 & lk.scl_d;
    // Data moving while the clock stays high is a bus condition.
    start_seen = lk.scl_s2 & lk.scl_d & lk.sda_d & ~lk.sda_s2;
    stop_seen = lk.scl_s2 & lk.scl_d & ~lk.sda_d & lk.sda_s2;
    rx = {lk.shreg[6:0], lk.sda_s2};
    if (start_seen) begin
      next_lk.st = LCP_LK_ADDR;
      next_lk.bitcnt = 4'h0;
      next_lk.ack_drive = 1'b0;
      next_lk.ack_want = 1'b0;
    end else if (stop_seen) begin
      next_lk.st = LCP_LK_IDLE;
      next_lk.bitcnt = 4'h0;
      next_lk.ack_drive = 1'b0;
      next_lk.ack_want = 1'b0;
    end else begin
      unique case (lk.st)
        LCP_LK_IDLE, LCP_LK_SKIP: begin
          next_lk.ack_drive = 1'b0;
        end
        LCP_LK_ADDR, LCP_LK_CTRL, LCP_LK_BYTE: begin
          if (scl_rise && lk.bitcnt < LCP_BITS_PER_BYTE) begin
            next_lk.shreg = rx;
            next_lk.bitcnt = lk.bitcnt + 4'h1;
            if (lk.bitcnt == LCP_BITS_PER_BYTE - 4'h1) begin
              next_lk.ack_want = 1'b1;
              if (lk.st == LCP_LK_ADDR) begin
                // Both strap levels share one upper address.
                if (rx[7:2] != LCP_ADDR_HIGH || rx[1] != lk.sa_s2 ||
                    rx[0]) begin
                  next_lk.ack_want = 1'b0;
                  next_lk.st = LCP_LK_SKIP;
                end else begin
                  next_lk.st = LCP_LK_CTRL;
                end
              end else if (lk.st == LCP_LK_CTRL) begin
                next_lk.more_follows_flag = rx[LCP_CTRL_MORE_BIT];
                next_lk.byte_route_select = rx[LCP_CTRL_ROUTE_BIT];
                next_lk.st = LCP_LK_BYTE;
              end else begin
                next_lk.xfer.is_data = lk.byte_route_select;
                next_lk.xfer.value = rx;
                next_lk.xfer_tgl = ~lk.xfer_tgl;
                if (lk.byte_route_select) begin
                  next_lk.ack_want = lk.match_s2;
                end
                if (lk.more_follows_flag) begin
                  next_lk.st = LCP_LK_CTRL;
                end
              end
            end
          end else if (scl_rise && lk.bitcnt == LCP_BITS_PER_BYTE) begin
            next_lk.bitcnt = LCP_ACK_SLOT;
          end else if (scl_fall && lk.bitcnt == LCP_BITS_PER_BYTE) begin
            // Pull low from the falling edge before the ninth pulse.
            next_lk.ack_drive = lk.ack_want;
          end else if (scl_fall && lk.bitcnt == LCP_ACK_SLOT) begin
            next_lk.ack_drive = 1'b0;
            next_lk.ack_want = 1'b0;
            next_lk.bitcnt = 4'h0;
          end
        end
        default: begin
          next_lk.st = LCP_LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lk <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1,
              sda_s2: 1'b1, sda_d: 1'b1, st: LCP_LK_IDLE, default: '0};
    end else begin
      lk <= next_lk;
    end
  end

  // Only the acknowledge leaves the link side as a pin.
  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACK_OUT_PIN <= 1'b1;
      ACK_OUT_PIN_OE <= 1'b0;
    end else begin
      ACK_OUT_PIN <= ~next_lk.ack_drive;
      ACK_OUT_PIN_OE <= next_lk.ack_drive;
    end
  end

  // System side: takes each byte across and decodes it.
  always_comb begin
    logic [7:0] b;
    logic fresh;
    logic two_bank;
    b = lk.xfer.value;
    fresh = 1'b0;
    two_bank = 1'b0;
    next_sy = sy;
    next_sy.tgl_s1 = lk.xfer_tgl;
    next_sy.tgl_s2 = sy.tgl_s1;
    next_sy.tgl_d = sy.tgl_s2;
    next_sy.strap_s1 = {STRAP_BIT_2, STRAP_BIT_1, STRAP_BIT_0};
    next_sy.strap_s2 = sy.strap_s1;
    next_sy.match = (sy.strap_s2 == SUBADDR_COUNT);
    next_sy.ptr_load = 1'b0;
    next_sy.sub_load = 1'b0;
    next_sy.write_strobe = 1'b0;
    // The byte is held on the link side for a whole byte time.
    fresh = sy.tgl_s2 ^ sy.tgl_d;
    two_bank = sy.mode.drive_mode == LCP_DRIVE_STATIC ||
               sy.mode.drive_mode == LCP_DRIVE_MUX2;
    if (fresh && lk.xfer.is_data) begin
      next_sy.write_strobe = sy.match;
      next_sy.write_data = b;
    end else if (fresh) begin
      if (!b[7]) begin
        next_sy.ptr_load = 1'b1;
        next_sy.ptr_value = b[6:0];
      end else if (b[7:4] == LCP_OP_MODE_SET) begin
        next_sy.mode.display_enable = b[LCP_MODE_ENABLE_BIT];
        next_sy.mode.bias_half = b[LCP_MODE_BIAS_BIT];
        next_sy.mode.drive_mode = b[1:0];
      end else if (b[7:3] == LCP_OP_DEV_SEL) begin
        next_sy.sub_load = 1'b1;
        next_sy.sub_value = b[2:0];
      end else if (b[7:2] == LCP_OP_BANK_SEL) begin
        if (two_bank) begin
          next_sy.mode.input_bank = b[LCP_BANK_IN_BIT];
          next_sy.mode.output_bank = b[LCP_BANK_OUT_BIT];
        end
      end else if (b[7:3] == LCP_OP_BLINK_SEL) begin
        next_sy.mode.bank_toggle_blink = b[LCP_BLINK_ALT_BIT] &
                                         two_bank;
        next_sy.mode.flash_rate = b[1:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sy <= '{mode: '{display_enable: LCP_RST_ENABLE,
                      bias_half: LCP_RST_BIAS_HALF,
                      drive_mode: LCP_RST_DRIVE,
                      flash_rate: LCP_RST_FLASH, default: '0},
              default: '0};
    end else begin
      sy <= next_sy;
    end
  end

  assign PTR_LOAD = sy.ptr_load;
  assign PTR_VALUE = sy.ptr_value;
  assign SUBADDR_LOAD = sy.sub_load;
  assign SUBADDR_VALUE = sy.sub_value;
  assign WRITE_STROBE = sy.write_strobe;
  assign WRITE_DATA = sy.write_data;
  assign MODE_STATE = sy.mode;

endmodule

// ### dv/lcp_command_port_sva.sv
// Checker of the command port acknowledge pin and load pulses.
`timescale 1ns/1ps
module lcp_command_port_sva
  import lcp_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic SCL,
  input wire logic STRAP_BIT_0,
  input wire logic STRAP_BIT_1,
  input wire logic STRAP_BIT_2,
  input wire logic [2:0] SUBADDR_COUNT,
  input wire logic ACK_OUT_PIN,
  input wire logic ACK_OUT_PIN_OE,
  input wire logic PTR_LOAD,
  input wire logic [6:0] PTR_VALUE,
  input wire logic SUBADDR_LOAD,
  input wire logic WRITE_STROBE
);
  sequence s_ack_high;
    ACK_OUT_PIN_OE && SCL ##1 SCL;
  endsequence
  chk_ack_level: assert property (@(posedge LINK_CLK)
    disable iff (!RESETN) ACK_OUT_PIN_OE |-> !ACK_OUT_PIN)
    else $error("ack enable without low level");
  chk_ack_held: assert property (@(posedge LINK_CLK)
    disable iff (!RESETN) s_ack_high |-> ACK_OUT_PIN_OE)
    else $error("ack dropped while clock high");
  chk_ack_start: assert property (@(posedge LINK_CLK)
    disable iff (!RESETN) $rose(ACK_OUT_PIN_OE) |-> !SCL)
    else $error("ack began while clock high");
  chk_ptr_pulse: assert property (@(posedge CLK)
    disable iff (!RESETN) PTR_LOAD |=> !PTR_LOAD)
    else $error("pointer load longer than one cycle");
  chk_sub_pulse: assert property (@(posedge CLK)
    disable iff (!RESETN) SUBADDR_LOAD |=> !SUBADDR_LOAD)
    else $error("subaddress load longer than one cycle");
  chk_wr_pulse: assert property (@(posedge CLK)
    disable iff (!RESETN) WRITE_STROBE |=> !WRITE_STROBE)
    else $error("write strobe longer than one cycle");
  chk_wr_match: assert property (@(posedge CLK)
    disable iff (!RESETN) WRITE_STROBE |->
    SUBADDR_COUNT == {STRAP_BIT_2, STRAP_BIT_1, STRAP_BIT_0})
    else $error("write strobe without subaddress match");
  chk_ptr_hold: assert property (@(posedge CLK)
    disable iff (!RESETN) !PTR_LOAD |-> $stable(PTR_VALUE))
    else $error("pointer value moved without load");
endmodule
bind lcp_command_port lcp_command_port_sva u_sva (
  .CLK, .RESETN, .LINK_CLK, .SCL, .STRAP_BIT_0, .STRAP_BIT_1,
  .STRAP_BIT_2, .SUBADDR_COUNT, .ACK_OUT_PIN, .ACK_OUT_PIN_OE,
  .PTR_LOAD, .PTR_VALUE, .SUBADDR_LOAD, .WRITE_STROBE
);

// ### dv/lcp_bus_master.sv
// Serial bus master model that writes bytes to the command port.
`timescale 1ns/1ps
module lcp_bus_master (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  task automatic start();
    sda <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b0;
    half();
    scl <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stop();
    sda <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b1;
    half();
  endtask
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      sda <= b[i];
      half();
      scl <= 1'b1;
      half();
      scl <= 1'b0;
      @(posedge clk);
    end
    if (n == 8) begin
      sda <= 1'b1;
      half();
      scl <= 1'b1;
      repeat (2) @(posedge clk);
      ack = sda_in;
      repeat (2) @(posedge clk);
      scl <= 1'b0;
      @(posedge clk);
    end
  endtask
endmodule

// ### dv/tb.sv
// Testbench of the LCD driver serial command port.
`timescale 1ns/1ps
module tb;
  import lcp_pkg::*;
  logic CLK = 0, LINK_CLK = 0, RESETN = 0, sa = 0, a;
  logic [2:0] st = 0, sc = 0, sv;
  logic [31:0] lf = 32'h6d533e0b;
  logic ack_oe, ack, pl, sl, ws, scl, sdm;
  logic [6:0] pv;
  logic [7:0] wd;
  logic [9:0] g;
  lcp_mode_t ms;
  logic [9:0] q[$];
  int n_fail = 0, check_count = 0;
  wire sda = sdm & (ack | ~ack_oe);
  initial forever #50 CLK = ~CLK;
  initial begin
    #7;
    forever #16 LINK_CLK = ~LINK_CLK;
  end
  lcp_command_port dut (.CLK(CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK),
    .SCL(scl), .SDA(sda), .ADDR_LSB_STRAP(sa), .STRAP_BIT_0(st[0]),
    .STRAP_BIT_1(st[1]), .STRAP_BIT_2(st[2]), .SUBADDR_COUNT(sc),
    .ACK_OUT_PIN(ack), .ACK_OUT_PIN_OE(ack_oe), .PTR_LOAD(pl),
    .PTR_VALUE(pv), .SUBADDR_LOAD(sl), .SUBADDR_VALUE(sv),
    .WRITE_STROBE(ws), .WRITE_DATA(wd), .MODE_STATE(ms));
  lcp_bus_master m (.clk(CLK), .sda_in(sda), .scl(scl), .sda(sdm));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [9:0] e, input logic [9:0] v);
    check_count++;
    if (v !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, v, e);
    end
  endtask
  task automatic xb(input logic [7:0] b, input logic e);
    m.send(b, 8, a);
    chk({9'h0, ~e}, {9'h0, a});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Each load pulse is matched against the oldest note.
  always @(negedge CLK) begin
    if (RESETN && (pl || sl || ws)) begin
      g = pl ? {3'h0, pv} : sl ? {5'h8, 2'h0, sv} : {2'h2, wd};
      chk(q.size() > 0 ? q.pop_front() : 10'h3ff, g);
    end
  end
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    st <= lf[2:0];
    sc <= lf[2:0];
    repeat (10) @(posedge CLK);
    chk(10'h020, {1'b0, ms});
    m.start();
    xb(8'h70, 1'b1);
    xb(8'h00, 1'b1);
    xb(8'hce, 1'b1);
    xb(8'hfb, 1'b1);
    xb(8'hf7, 1'b1);
    q.push_back({5'h8, 2'h0, st});
    xb({5'h1c, st}, 1'b1);
    lf = nx(lf);
    q.push_back({3'h0, lf[6:0]});
    xb({1'b0, lf[6:0]}, 1'b1);
    m.stop();
    chk(10'h1df, {1'b0, ms});
    $display("command test done");
    m.start();
    xb(8'h70, 1'b1);
    xb(8'h80, 1'b1);
    xb(8'hc3, 1'b1);
    xb(8'h00, 1'b1);
    xb(8'hf8, 1'b1);
    xb(8'hf5, 1'b1);
    m.stop();
    chk(10'h079, {1'b0, ms});
    $display("multiplex test done");
    m.start();
    xb(8'h70, 1'b1);
    xb(8'hc0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      q.push_back({2'h2, lf[7:0]});
      xb(lf[7:0], 1'b1);
      if (i == 0) xb(8'h40, 1'b1);
    end
    m.stop();
    @(posedge CLK);
    sc <= st + 3'h1;
    repeat (10) @(posedge CLK);
    m.start();
    xb(8'h70, 1'b1);
    xb(8'h40, 1'b1);
    lf = nx(lf);
    xb(lf[7:0], 1'b0);
    m.stop();
    sc <= st;
    $display("data test done");
    m.start();
    xb(8'h72, 1'b0);
    xb(8'hc1, 1'b0);
    m.start();
    xb(8'h71, 1'b0);
    m.start();
    m.send(8'h70, 3, a);
    m.start();
    xb(8'h70, 1'b1);
    xb(8'h00, 1'b1);
    xb(8'hd5, 1'b1);
    xb(8'hc8, 1'b1);
    m.stop();
    chk(10'h119, {1'b0, ms});
    @(posedge CLK);
    sa <= 1'b1;
    repeat (10) @(posedge CLK);
    m.start();
    xb(8'h72, 1'b1);
    xb(8'h70, 1'b1);
    m.stop();
    // Static drive keeps both banks and alternate blinking available.
    m.start();
    xb(8'h72, 1'b1);
    xb(8'h00, 1'b1);
    xb(8'hc9, 1'b1);
    xb(8'hf8, 1'b1);
    xb(8'hf6, 1'b1);
    m.stop();
    chk(10'h126, {1'b0, ms});
    $display("address test done");
    repeat (20) @(posedge CLK);
    chk(10'h0, 10'(q.size()));
    final_report();
  end
endmodule
